// ---- src/sep_pkg.sv ----
package sep_pkg;

    // Array organisation: 64 words of 16 bits, 6-bit word address
    localparam int unsigned SEP_ADDR_W = 6;
    localparam int unsigned SEP_WORD_W = 16;
    localparam int unsigned SEP_WORDS  = 64;

    // Bit positions counted after the start bit, then the top read bit index and the top word address
    localparam logic [4:0] SEP_CMD_AT   = 5'h04;
    localparam logic [4:0] SEP_HDR_END  = 5'h08;
    localparam logic [4:0] SEP_DATA_END = 5'h18;
    localparam logic [4:0] SEP_NBITS_MAX = 5'h1F;
    localparam logic [3:0] SEP_RD_TOP   = 4'hF;
    localparam logic [5:0] SEP_ADDR_TOP = 6'h3F;

    // Opcode and extended sub-code encodings
    localparam logic [1:0] SEP_OP_EXT   = 2'h0;
    localparam logic [1:0] SEP_OP_WRITE = 2'h1;
    localparam logic [1:0] SEP_OP_READ  = 2'h2;
    localparam logic [1:0] SEP_OP_ERASE = 2'h3;
    localparam logic [1:0] SEP_SUB_LOCK   = 2'h0;
    localparam logic [1:0] SEP_SUB_FILL   = 2'h1;
    localparam logic [1:0] SEP_SUB_CLEAR  = 2'h2;
    localparam logic [1:0] SEP_SUB_UNLOCK = 2'h3;

    localparam logic [15:0] SEP_ERASED = 16'hFFFF;

    // Reset values
    localparam logic SEP_PROG_EN_RST = 1'b0;
    localparam logic SEP_STATUS_RST  = 1'b1;

    // Programming cycle: longest time, rounded down to whole cycles
    localparam int unsigned SEP_PROG_TIME_US  = 4000;
    localparam int unsigned SEP_CLK_PERIOD_NS = 100;
    localparam int unsigned SEP_PROG_CYCLES   = SEP_PROG_TIME_US * 1000 / SEP_CLK_PERIOD_NS;

endpackage : sep_pkg

// ---- src/sep_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Rising shift clocks with input low before a start bit are ignored.
// - Input high while status shows ready is a start bit; output floats.
// - After last read address bit, output goes low for one clock.
// - Then the addressed 16-bit word shifts out, one bit per clock.
// - Further clocks with select high increment address and read on.
// - Programming begins at select low only after the exact clock count.
// - During a programming cycle clocks and input are ignored; the code still takes a start bit on a frame's first two shift clocks.
// - Programming instructions act only in program-enable mode.
// - Every programming cycle completes within 4 ms.
// - Select high during programming shows low while busy, high when done.
// - Word write is start, opcode, address, 16 data bits; overwrites directly.
// - Extra clocks on a programming instruction cancel it.
// - Word erase sets the addressed word to all ones.
// - Fill-all writes one word everywhere; address bits ignored.
// - Clear-all sets every bit to one; no data, address ignored.
// - Unlock and lock take effect when select falls.
// - Select low means standby and ends any instruction input.
// - Input sampled on rising shift clock: start, opcode, address, data.
// - Opcodes read 10, write 01, erase 11; 00 plus sub-code for the rest.
// - Reset cancels pending programming and enters program-disable mode.

module sep_core
    import sep_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = SEP_PROG_CYCLES
)(
    input  wire logic clk_i,
    input  wire logic srst_i,
    input  wire logic shift_clock_pin_i,
    input  wire logic select_pin_i,
    input  wire logic serial_in_pin_i,
    output logic      serial_out_pin_o,
    output logic      serial_out_oe_o,
    output logic      prog_busy_o
);

    function automatic logic is_prog(input logic [3:0] c);
        return (c[3:2] == SEP_OP_WRITE) || (c[3:2] == SEP_OP_ERASE) ||
               ((c[3:2] == SEP_OP_EXT) && ((c[1:0] == SEP_SUB_FILL) || (c[1:0] == SEP_SUB_CLEAR)));
    endfunction : is_prog

    function automatic logic is_mode(input logic [3:0] c);
        return (c[3:2] == SEP_OP_EXT) && ((c[1:0] == SEP_SUB_UNLOCK) || (c[1:0] == SEP_SUB_LOCK));
    endfunction : is_mode

    function automatic logic [4:0] prog_len(input logic [3:0] c);
        return ((c[3:2] == SEP_OP_WRITE) || ((c[3:2] == SEP_OP_EXT) && (c[1:0] == SEP_SUB_FILL)))
               ? SEP_DATA_END : SEP_HDR_END;
    endfunction : prog_len

    // Nonvolatile contents are not touched by reset
    logic [15:0] mem [SEP_WORDS];

    // Link side, clocked by the shift clock
    logic        frame_act;
    logic [4:0]  nbits;
    logic [15:0] sr;
    logic [3:0]  cmd_q;
    logic [5:0]  addr_q;
    logic        arm_tgl;
    logic        rd_run;
    logic        rd_oe;
    logic        rd_bit;
    logic [5:0]  rd_addr;
    logic [3:0]  rd_idx;
    logic [1:0]  busy_sync;

    // Core side, clocked by clk_i
    logic [2:0]  cs_sync;
    logic        cs_level;
    logic [1:0]  arm_sync;
    logic        arm_seen;
    logic        busy;
    logic [15:0] prog_cnt;
    logic        prog_en;
    logic        status_pend;
    logic        status_on;
    logic        status_bit;

    wire         busy_sk    = busy_sync[1];
    wire         take_start = !frame_act && serial_in_pin_i && !busy_sk;
    wire [4:0]   n_next     = (nbits == SEP_NBITS_MAX) ? nbits : nbits + 5'h01;
    wire         bit_new    = frame_act && (n_next != nbits);
    wire [3:0]   cmd_now    = {sr[2:0], serial_in_pin_i};
    wire [5:0]   addr_now   = {sr[4:0], serial_in_pin_i};
    wire         at_cmd     = bit_new && (n_next == SEP_CMD_AT);
    wire         at_hdr     = bit_new && (n_next == SEP_HDR_END);
    wire         rd_go      = at_hdr && (cmd_q[3:2] == SEP_OP_READ);
    wire [4:0]   plen       = prog_len(cmd_q);
    wire         prog_seen  = bit_new && is_prog(cmd_q) && (nbits >= SEP_CMD_AT);
    // Toggle once when a mode sub-code arrives or at a programming instruction's exact count, and back on its first extra clock
    wire         arm_flip   = (at_cmd && is_mode(cmd_now)) ||
                              (prog_seen && ((n_next == plen) || (n_next == plen + 5'h01)));
    wire [15:0]  rd_word    = mem[rd_addr];
    wire         rd_msb     = rd_word[15];

    wire         cs_agree      = cs_sync[1] == cs_sync[2];
    wire         next_cs_level = cs_agree ? cs_sync[2] : cs_level;
    wire         cs_fall       = cs_level && !next_cs_level;
    wire         armed         = arm_sync[1] != arm_seen;
    wire         commit        = cs_fall && armed && !busy;
    wire         do_mode       = commit && is_mode(cmd_q);
    wire         do_prog       = commit && is_prog(cmd_q) && prog_en;
    wire         prog_done     = busy && (prog_cnt == 16'(PROG_CYCLES - 1));
    wire         wr_ones       = (cmd_q[3:2] == SEP_OP_ERASE) ||
                                 ((cmd_q[3:2] == SEP_OP_EXT) && (cmd_q[1:0] == SEP_SUB_CLEAR));
    wire         wr_all        = cmd_q[3:2] == SEP_OP_EXT;
    wire [15:0]  wr_val        = wr_ones ? SEP_ERASED : sr;

    // Select low clears the frame at once, since the shift clock stops with it
    always_ff @(posedge shift_clock_pin_i or negedge select_pin_i)
    begin
        if (!select_pin_i)
        begin
            frame_act <= 1'b0;
            nbits     <= 5'h00;
        end
        else
        begin
            if (take_start)
                frame_act <= 1'b1;
            if (frame_act)
                nbits <= n_next;
        end
    end

    always_ff @(posedge shift_clock_pin_i or negedge select_pin_i)
    begin
        if (!select_pin_i)
        begin
            rd_run  <= 1'b0;
            rd_oe   <= 1'b0;
            rd_bit  <= 1'b0;
            rd_addr <= 6'h00;
            rd_idx  <= 4'h0;
        end
        else if (rd_go)
        begin
            rd_oe   <= 1'b1;
            rd_bit  <= 1'b0;
            rd_run  <= 1'b1;
            rd_addr <= addr_now;
            rd_idx  <= SEP_RD_TOP;
        end
        else if (rd_run)
        begin
            rd_bit <= rd_word[rd_idx];
            rd_idx <= rd_idx - 4'h1;
            if (rd_idx == 4'h0)
                rd_addr <= rd_addr + 6'h01;
        end
    end

    // Payload must outlive select low, so only the reset clears it; the core
    // reads it after select has fallen and the shift clock has stopped
    always_ff @(posedge shift_clock_pin_i or posedge srst_i)
    begin
        if (srst_i)
        begin
            sr      <= 16'h0000;
            cmd_q   <= 4'h0;
            addr_q  <= 6'h00;
            arm_tgl <= 1'b0;
        end
        else
        begin
            if (frame_act)
                sr <= {sr[14:0], serial_in_pin_i};
            if (at_cmd)
                cmd_q <= cmd_now;
            if (at_hdr)
                addr_q <= addr_now;
            if (arm_flip)
                arm_tgl <= ~arm_tgl;
        end
    end

    always_ff @(posedge shift_clock_pin_i or posedge srst_i)
    begin
        if (srst_i)
            busy_sync <= 2'h0;
        else
            busy_sync <= {busy_sync[0], busy};
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            cs_sync  <= 3'h0;
            cs_level <= 1'b0;
            arm_sync <= 2'h0;
            arm_seen <= 1'b0;
        end
        else
        begin
            cs_sync  <= {cs_sync[1:0], select_pin_i};
            cs_level <= next_cs_level;
            arm_sync <= {arm_sync[0], arm_tgl};
            if (cs_fall)
                arm_seen <= arm_sync[1];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            busy     <= 1'b0;
            prog_cnt <= 16'h0000;
        end
        else if (do_prog)
        begin
            busy     <= 1'b1;
            prog_cnt <= 16'h0000;
        end
        else if (prog_done)
            busy <= 1'b0;
        else if (busy)
            prog_cnt <= prog_cnt + 16'h0001;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            prog_en <= SEP_PROG_EN_RST;
        else if (do_mode)
            prog_en <= cmd_q[1:0] == SEP_SUB_UNLOCK;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            status_pend <= 1'b0;
            status_on   <= 1'b0;
            status_bit  <= SEP_STATUS_RST;
        end
        else
        begin
            if (do_prog)
                status_pend <= 1'b1;
            else if (cs_fall && !busy)
                status_pend <= 1'b0;
            status_on  <= next_cs_level && status_pend;
            status_bit <= !busy;
        end
    end

    // Addressed word, or every word for fill and clear, updates in the commit cycle; the timer models the cell time
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < SEP_WORDS; i++)
        begin
            if (do_prog && (wr_all || (addr_q == 6'(i))))
                mem[i] <= wr_val;
        end
    end

    // Read data and status come from two clock domains; a start bit masks
    // the status drive immediately rather than after a crossing delay
    assign serial_out_pin_o = rd_oe ? rd_bit : status_bit;
    assign serial_out_oe_o  = rd_oe | (status_on & ~frame_act);
    assign prog_busy_o      = busy;

    sequence seq_rd_hdr;
        rd_go;
    endsequence

    sequence seq_dummy_low;
        serial_out_oe_o && !serial_out_pin_o;
    endsequence

    sequence seq_msb_out;
        serial_out_oe_o && (serial_out_pin_o == $past(rd_msb));
    endsequence

    sequence seq_exact_count;
        prog_seen && (n_next == plen);
    endsequence

    chk_read_dummy_low: assert property (
        @(posedge shift_clock_pin_i) disable iff (srst_i || !select_pin_i)
        seq_rd_hdr |=> seq_dummy_low ##1 seq_msb_out)
        else $error("read dummy bit or first data bit wrong");

    chk_dummy_clock_ignored: assert property (
        @(posedge shift_clock_pin_i) disable iff (srst_i || !select_pin_i)
        (!frame_act && !serial_in_pin_i) |=> (!frame_act && (nbits == 5'h00)))
        else $error("dummy clock started or altered a frame");

    chk_busy_no_start: assert property (
        @(posedge shift_clock_pin_i) disable iff (srst_i || !select_pin_i)
        (busy_sk && !frame_act) |=> !frame_act)
        else $error("instruction accepted while programming");

    chk_start_floats_out: assert property (
        @(posedge shift_clock_pin_i) disable iff (srst_i || !select_pin_i)
        take_start |=> !serial_out_oe_o)
        else $error("output still driven after start bit");

    chk_read_addr_step: assert property (
        @(posedge shift_clock_pin_i) disable iff (srst_i || !select_pin_i)
        (rd_run && !rd_go && (rd_idx == 4'h0)) |=> (rd_addr == 6'($past(rd_addr) + 6'h01)))
        else $error("sequential read address did not advance");

    chk_read_addr_wrap: assert property (
        @(posedge shift_clock_pin_i) disable iff (srst_i || !select_pin_i)
        (rd_run && !rd_go && (rd_idx == 4'h0) && (rd_addr == SEP_ADDR_TOP)) |=> (rd_addr == 6'h00))
        else $error("sequential read did not wrap to zero");

    chk_overcount_cancel: assert property (
        @(posedge shift_clock_pin_i) disable iff (srst_i || !select_pin_i)
        seq_exact_count ##1 frame_act |=> (arm_tgl == $past(arm_tgl, 2)))
        else $error("extra clock did not cancel programming");

    chk_prog_bound: assert property (
        @(posedge clk_i) disable iff (srst_i)
        busy |-> (prog_cnt < 16'(PROG_CYCLES)))
        else $error("programming cycle ran too long");

    chk_prog_cause: assert property (
        @(posedge clk_i) disable iff (srst_i)
        $rose(busy) |-> $past(cs_fall))
        else $error("programming started without select falling");

    chk_lock_guard: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (commit && is_prog(cmd_q) && !prog_en) |=> !busy)
        else $error("programming ran in program-disable mode");

    chk_unlock_mode: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (do_mode && (cmd_q[1:0] == SEP_SUB_UNLOCK)) |=> prog_en)
        else $error("unlock did not enter program-enable mode");

    chk_status_busy_low: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (status_on && !rd_oe && busy && $past(busy)) |-> (serial_out_oe_o == !frame_act) && !serial_out_pin_o)
        else $error("busy status not shown low");

    chk_reset_locks: assert property (
        @(posedge clk_i) disable iff (srst_i)
        $fell(srst_i) |-> (!prog_en && !busy))
        else $error("reset left programming enabled");

    chk_float_idle: assert property (
        @(posedge clk_i) disable iff (srst_i)
        (!cs_level && !$past(cs_level) && !select_pin_i) |-> !serial_out_oe_o)
        else $error("output driven with select low");

endmodule : sep_core
`default_nettype wire

// ---- test/sep_host.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host model on the serial link; its shift clock runs only inside frames
module sep_host (
    output logic      sk_o,
    output logic      cs_o,
    output logic      di_o,
    input  wire logic do_i,
    input  wire logic oe_i
);
    initial
    begin
        sk_o = 1'b0;
        di_o = 1'b0;
        // Select falls just after time zero so the link flops see a clearing edge
        #1;
        cs_o = 1'b0;
    end

    // One 64 ns shift clock; data moves in the low half, read data is taken before the rise
    task automatic tick(input logic b, output logic q);
        di_o = b;
        #32;
        q = oe_i ? do_i : 1'bz;
        sk_o = 1'b1;
        #32;
        sk_o = 1'b0;
    endtask : tick

    // Frames are padded to 32 clocks with leading dummy zeros
    task automatic send(input logic [31:0] v);
        logic q;
        cs_o = 1'b1;
        #20;
        for (int i = 31; i >= 0; i--)
        begin
            tick(v[i], q);
        end
    endtask : send

    task automatic word(output logic [15:0] w);
        logic q;
        for (int i = 15; i >= 0; i--)
        begin
            tick(1'b0, q);
            w[i] = q;
        end
    endtask : word

    // The released input is inverted so a stale level never looks like a drive
    task automatic stop;
        di_o = ~di_o;
        cs_o = 1'b0;
        #500;
    endtask : stop

    // Input held low while polling, select left high on return
    task automatic poll(output logic [1:0] first, output int n);
        cs_o = 1'b1;
        di_o = 1'b0;
        n = 0;
        // Select reaches the status logic through a three-flop synchroniser
        #500;
        first = {oe_i, do_i};
        while (!(oe_i === 1'b1 && do_i === 1'b1) && n < 2000)
        begin
            #100;
            n++;
        end
    endtask : poll
endmodule : sep_host
`default_nettype wire

// ---- test/sep_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sep_core_tb;
    import sep_pkg::*;

    localparam int unsigned PC = 50;
    logic       clk_i;
    logic       srst_i;
    logic       sk;
    logic       cs;
    logic       di;
    logic       so;
    logic       oe;
    logic       busy;
    int         error_cnt;
    int         num_checks;
    logic [15:0] w;
    logic [21:0] rows [4] = '{{6'h00, 16'hA5C3}, {6'h3F, 16'h0001}, {6'h15, 16'h8000}, {6'h2A, 16'h7FFE}};

    sep_host h (.sk_o(sk), .cs_o(cs), .di_o(di), .do_i(so), .oe_i(oe));

    sep_core #(.PROG_CYCLES(PC)) dut (
        .clk_i            (clk_i),
        .srst_i           (srst_i),
        .shift_clock_pin_i(sk),
        .select_pin_i     (cs),
        .serial_in_pin_i  (di),
        .serial_out_pin_o (so),
        .serial_out_oe_o  (oe),
        .prog_busy_o      (busy)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic results;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Programming must start, show busy, then report ready within the scaled cycle time plus ten 100 ns polls
    task automatic wp;
        logic [1:0] f;
        int         n;
        repeat (4) @(posedge clk_i);
        chk("busy", {15'h0, busy}, 16'h1);
        h.poll(f, n);
        chk("status", {14'h0, f}, 16'h2);
        chk("ready", {15'h0, n < PC + 10}, 16'h1);
        if (n >= 2000)
            results();
    endtask : wp

    task automatic np;
        repeat (6) @(posedge clk_i);
        chk("idle", {15'h0, busy}, 16'h0);
    endtask : np

    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        logic q;
        h.send({23'h0, 3'b110, a});
        h.tick(1'b0, q);
        chk("dummy", {15'h0, q}, 16'h0);
        h.word(w);
        chk("word", w, e);
    endtask : rd

    initial
    begin
        #5000000;
        error_cnt++;
        results();
    end

    initial
    begin
        error_cnt = 0;
        num_checks = 0;
        // Reset rises after time zero so the asynchronously cleared flops see an edge
        #1;
        srst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        chk("rst_busy", {15'h0, busy}, 16'h0);
        chk("rst_oe", {15'h0, oe}, 16'h0);
        srst_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        h.send({23'h0, 9'b1_00_11_0000});
        h.stop();
        np();
        h.send({23'h0, 9'b1_00_10_1010});
        h.stop();
        wp();
        rd(6'h10, SEP_ERASED);
        h.stop();
        // Writes carry 7 dummy clocks; reads start straight from the ready status
        foreach (rows[i])
        begin
            h.send({7'h0, 3'b101, rows[i]});
            h.stop();
            wp();
            rd(rows[i][21:16], rows[i][15:0]);
            h.stop();
        end
        rd(6'h3F, 16'h0001);
        h.word(w);
        chk("wrap", w, 16'hA5C3);
        h.stop();
        h.send({5'h0, 3'b101, 6'h00, 16'hDEAD, 2'b0});
        h.stop();
        np();
        rd(6'h00, 16'hA5C3);
        h.stop();
        h.send({23'h0, 3'b111, 6'h15});
        h.stop();
        wp();
        rd(6'h15, SEP_ERASED);
        h.stop();
        h.send({7'h0, 9'b1_00_01_0101, 16'h1234});
        h.stop();
        h.send({7'h0, 3'b101, 6'h2A, 16'h0000});
        h.stop();
        wp();
        rd(6'h2A, 16'h1234);
        h.stop();
        h.send({23'h0, 9'b1_00_00_0000});
        h.stop();
        np();
        h.send({7'h0, 3'b101, 6'h00, 16'h0000});
        h.stop();
        np();
        rd(6'h00, 16'h1234);
        h.stop();
        results();
    end
endmodule : sep_core_tb
`default_nettype wire
